// file: verilog/timer_channel_pin_control.sv
// timer with capture, compare and pwm channels and their pin control
//
// How it works
// - center-aligned select makes counter up/down; capture, compare, edge pwm unavailable.
// - after reset nothing enabled; unused pins left to general-purpose control.
// - clock source offers none, bus clock, fixed clock or external input.
// - external clock synchronised on bus clock; source at most quarter bus rate.
// - with external clock, pinless compare still works as software timer.
// - pin released when edge/level select or clock select is zero.
// - center-aligned with nonzero edge/level owns pins; else mode select picks function.
// - capture forces edge input; edge/level select chooses edges.
// - capture input through bus-clock synchroniser; four-clock pulses always seen.
// - compare drives pin, toggling, clearing or setting on each match.
// - toggle keeps previous level until the next match.
// - edge pwm sets pin at count zero, clears at match.
// - edge pwm low-true: set at match, clear at period start.
// - center pwm clears on up match, sets on down match.
// - center pwm inverted: sets on up match, clears on down match.
// - clock select codes 00 off, 01 bus, 10 fixed, 11 external.
// - center mode counts up to modulo, then down to zero, repeating.
// - any counter write resets it; reads leave counting alone.
`timescale 1ns/100ps
`include "timer_params.svh"
module timer_channel_pin_control
    import timer_pkg::*;
(
    input  wire logic                I_REF_CLK,
    input  wire logic                I_RST,
    input  wire logic                I_CE,
    input  wire logic                I_HSEL,
    input  wire logic [31:0]         I_HADDR,
    input  wire logic [1:0]          I_HTRANS,
    input  wire logic                I_HWRITE,
    input  wire logic [2:0]          I_HSIZE,
    input  wire logic [31:0]         I_HWDATA,
    input  wire logic                I_HREADY,
    output logic [31:0]              O_HRDATA,
    output logic                     O_HREADYOUT,
    output logic                     O_HRESP,
    input  wire logic                I_FIXED_CLK,
    input  wire logic                I_EXT_CLK,
    input  wire logic [`TMR_NCH-1:0] I_CH_PIN_IN,
    output logic [`TMR_NCH-1:0]      O_CH_PIN_OUT,
    output logic [`TMR_NCH-1:0]      O_CH_PIN_OE,
    output logic [`TMR_NCH-1:0]      O_CH_OWNED
);
    tmr_state_t          s_ff;
    tmr_state_t          nxt_s;
    logic                src_ev;
    logic                tick;
    logic                ovf_ev;
    logic                cnt_wr;
    logic [6:0]          pmask;
    logic [31:0]         rd;
    logic [`TMR_NCH-1:0] match;
    logic [`TMR_NCH-1:0] cap_ev;

    always_comb begin
        nxt_s = s_ff;
        // only whole words; hsize is ignored
        // first stages feed only second stages
        nxt_s.ext_sync = {s_ff.ext_sync[0], I_EXT_CLK};
        nxt_s.ext_prev = s_ff.ext_sync[1];
        nxt_s.fix_sync = {s_ff.fix_sync[0], I_FIXED_CLK};
        nxt_s.fix_prev = s_ff.fix_sync[1];
        nxt_s.cap_s1   = I_CH_PIN_IN;
        nxt_s.cap_s2   = s_ff.cap_s1;
        nxt_s.cap_prev = s_ff.cap_s2;

        case (s_ff.cks)
            CKS_OFF:   src_ev = 1'b0;
            CKS_BUS:   src_ev = 1'b1;
            CKS_FIXED: src_ev = s_ff.fix_sync[1] & ~s_ff.fix_prev;
            default:   src_ev = s_ff.ext_sync[1] & ~s_ff.ext_prev;
        endcase
        pmask = 7'((8'h01 << s_ff.ps) - 8'h01);
        tick  = src_ev && ((s_ff.presc & pmask) == pmask);
        if (src_ev) begin
            nxt_s.presc = s_ff.presc + 7'h01;
        end

        ovf_ev = 1'b0;
        if (tick) begin
            if (s_ff.center_aligned_select) begin
                if (s_ff.dir_up) begin
                    if (s_ff.cnt >= s_ff.modv) begin
                        nxt_s.dir_up = 1'b0;
                        nxt_s.cnt    = s_ff.cnt - 16'h0001;
                    end else begin
                        nxt_s.cnt = s_ff.cnt + 16'h0001;
                    end
                end else if (s_ff.cnt == 16'h0000) begin
                    nxt_s.dir_up = 1'b1;
                    nxt_s.cnt    = 16'h0001;
                    ovf_ev       = 1'b1;
                end else begin
                    nxt_s.cnt = s_ff.cnt - 16'h0001;
                end
            end else begin
                nxt_s.dir_up = 1'b1;
                if (s_ff.modv != 16'h0000 && s_ff.cnt >= s_ff.modv) begin
                    nxt_s.cnt = 16'h0000;
                    ovf_ev    = 1'b1;
                end else begin
                    nxt_s.cnt = s_ff.cnt + 16'h0001;
                    ovf_ev    = (s_ff.cnt == 16'hffff);
                end
            end
        end

        // data phase of a write; a back-to-back read sees the old value
        cnt_wr = 1'b0;
        if (s_ff.wr_pend) begin
            if (s_ff.wr_addr == `TMR_CTRL_ADDR) begin
                nxt_s.center_aligned_select = I_HWDATA[`TMR_CENTER_ALIGNED_SELECT_BIT];
                nxt_s.cks   = clk_src_t'(I_HWDATA[`TMR_CKS_LSB +: 2]);
                nxt_s.ps    = I_HWDATA[`TMR_PS_LSB +: 3];
                if (I_HWDATA[`TMR_OVF_BIT]) begin
                    nxt_s.ovf = 1'b0;
                end
            end else if (s_ff.wr_addr == `TMR_CNT_ADDR) begin
                cnt_wr = 1'b1;
            end else if (s_ff.wr_addr == `TMR_MOD_ADDR) begin
                nxt_s.modv = I_HWDATA[15:0];
            end
            for (int i = 0; i < `TMR_NCH; i++) begin
                if (s_ff.wr_addr == 8'(`TMR_CHC_BASE + `TMR_CH_STRIDE * i)) begin
                    nxt_s.ms[i] = I_HWDATA[`TMR_MS_LSB +: 2];
                    nxt_s.el[i] = I_HWDATA[`TMR_EL_LSB +: 2];
                    if (I_HWDATA[`TMR_CHF_BIT]) begin
                        nxt_s.flag[i] = 1'b0;
                    end
                end else if (s_ff.wr_addr == 8'(`TMR_CHV_BASE + `TMR_CH_STRIDE * i)) begin
                    nxt_s.val[i] = I_HWDATA[15:0];
                end
            end
        end
        if (cnt_wr) begin
            nxt_s.cnt    = 16'h0000;
            nxt_s.presc  = 7'h00;
            nxt_s.dir_up = 1'b1;
        end
        if (ovf_ev) begin
            nxt_s.ovf = 1'b1;
        end

        for (int i = 0; i < `TMR_NCH; i++) begin
            match[i]  = tick && (s_ff.cnt == s_ff.val[i]);
            cap_ev[i] = (s_ff.el[i][0] & s_ff.cap_s2[i] & ~s_ff.cap_prev[i])
                      | (s_ff.el[i][1] & ~s_ff.cap_s2[i] & s_ff.cap_prev[i]);
            if (s_ff.center_aligned_select) begin
                if (match[i]) begin
                    nxt_s.flag[i] = 1'b1;
                    if (s_ff.el[i] != 2'b00) begin
                        // el[0] picks polarity
                        nxt_s.lvl[i] = s_ff.dir_up ? s_ff.el[i][0] : ~s_ff.el[i][0];
                    end
                end
            end else if (s_ff.ms[i] == 2'b00) begin
                if (cap_ev[i]) begin
                    nxt_s.val[i]  = s_ff.cnt;
                    nxt_s.flag[i] = 1'b1;
                end
            end else if (s_ff.ms[i] == 2'b01) begin
                if (match[i]) begin
                    nxt_s.flag[i] = 1'b1;
                    case (s_ff.el[i])
                        2'b01:   nxt_s.lvl[i] = ~s_ff.lvl[i];
                        2'b10:   nxt_s.lvl[i] = 1'b0;
                        2'b11:   nxt_s.lvl[i] = 1'b1;
                        default: nxt_s.lvl[i] = s_ff.lvl[i];
                    endcase
                end
            end else begin
                if (match[i]) begin
                    nxt_s.flag[i] = 1'b1;
                end
                // a match at count zero wins, giving zero duty
                if (s_ff.el[i] != 2'b00) begin
                    if (match[i]) begin
                        nxt_s.lvl[i] = s_ff.el[i][0];
                    end else if (tick && s_ff.cnt == 16'h0000) begin
                        nxt_s.lvl[i] = ~s_ff.el[i][0];
                    end
                end
            end
            nxt_s.owned[i]  = (s_ff.cks != CKS_OFF) && (s_ff.el[i] != 2'b00);
            nxt_s.pin_oe[i] = nxt_s.owned[i] && (s_ff.center_aligned_select || s_ff.ms[i] != 2'b00);
        end
        nxt_s.pin_out = s_ff.lvl;

        // address phase: decode and prepare read data for the data phase
        rd = 32'h0000_0000;
        if (I_HADDR[7:0] == `TMR_CTRL_ADDR) begin
            rd[`TMR_OVF_BIT]      = s_ff.ovf;
            rd[`TMR_CENTER_ALIGNED_SELECT_BIT]    = s_ff.center_aligned_select;
            rd[`TMR_CKS_LSB +: 2] = s_ff.cks;
            rd[`TMR_PS_LSB +: 3]  = s_ff.ps;
        end else if (I_HADDR[7:0] == `TMR_CNT_ADDR) begin
            rd[15:0] = s_ff.cnt;
        end else if (I_HADDR[7:0] == `TMR_MOD_ADDR) begin
            rd[15:0] = s_ff.modv;
        end
        for (int i = 0; i < `TMR_NCH; i++) begin
            if (I_HADDR[7:0] == 8'(`TMR_CHC_BASE + `TMR_CH_STRIDE * i)) begin
                rd[`TMR_CHF_BIT]     = s_ff.flag[i];
                rd[`TMR_MS_LSB +: 2] = s_ff.ms[i];
                rd[`TMR_EL_LSB +: 2] = s_ff.el[i];
            end else if (I_HADDR[7:0] == 8'(`TMR_CHV_BASE + `TMR_CH_STRIDE * i)) begin
                rd[15:0] = s_ff.val[i];
            end
        end
        if (I_HADDR[31:8] != 24'h000000) begin
            rd = 32'h0000_0000;
        end
        nxt_s.hreadyout = 1'b1;
        nxt_s.wr_pend   = 1'b0;
        if (I_HSEL && I_HTRANS[1] && I_HREADY) begin
            nxt_s.wr_pend = I_HWRITE && (I_HADDR[31:8] == 24'h000000);
            nxt_s.wr_addr = I_HADDR[7:0];
            nxt_s.hrdata  = I_HWRITE ? 32'h0000_0000 : rd;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (I_RST) begin
            s_ff           <= '0;
            s_ff.hreadyout <= 1'b1;
            s_ff.dir_up    <= 1'b1;
        end else if (I_CE) begin
            s_ff <= nxt_s;
        end
    end

    assign O_HRDATA     = s_ff.hrdata;
    assign O_HREADYOUT  = s_ff.hreadyout;
    assign O_HRESP      = 1'b0;
    assign O_CH_PIN_OUT = s_ff.pin_out;
    assign O_CH_PIN_OE  = s_ff.pin_oe;
    assign O_CH_OWNED   = s_ff.owned;

    property p_cks_off;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (s_ff.cks == CKS_OFF) |-> !tick;
    endproperty
    a_cks_off: assert property (p_cks_off) else $error("tick with clock off");

    property p_bus_tick;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (s_ff.cks == CKS_BUS && s_ff.ps == 3'h0) |-> tick;
    endproperty
    a_bus_tick: assert property (p_bus_tick) else $error("bus clock not ticking");

    property p_cnt_wr;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (cnt_wr && I_CE) |=> (s_ff.cnt == 16'h0000);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr) else $error("counter write no reset");

    property p_down;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_CE && tick && !cnt_wr && s_ff.center_aligned_select && !s_ff.dir_up && s_ff.cnt != 16'h0000)
        |=> (s_ff.cnt == $past(s_ff.cnt) - 16'h0001);
    endproperty
    a_down: assert property (p_down) else $error("center count not down");

    property p_turn_up;
        @(posedge I_REF_CLK) disable iff (I_RST)
        (I_CE && tick && !cnt_wr && s_ff.center_aligned_select && !s_ff.dir_up && s_ff.cnt == 16'h0000)
        |=> (s_ff.dir_up && s_ff.cnt == 16'h0001);
    endproperty
    a_turn_up: assert property (p_turn_up) else $error("center count not turning");

    property p_reset_idle;
        @(posedge I_REF_CLK)
        I_RST |=> (O_CH_OWNED == '0 && O_CH_PIN_OE == '0
                   && s_ff.cks == CKS_OFF && !s_ff.center_aligned_select);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");

    genvar g;
    for (g = 0; g < `TMR_NCH; g++) begin : g_ch
        property p_release;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && (s_ff.cks == CKS_OFF || s_ff.el[g] == 2'b00))
            |=> (!O_CH_OWNED[g] && !O_CH_PIN_OE[g]);
        endproperty
        a_release: assert property (p_release) else $error("pin not released");

        property p_capture;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && !s_ff.center_aligned_select && s_ff.ms[g] == 2'b00 && cap_ev[g])
            |=> (s_ff.flag[g] && s_ff.val[g] == $past(s_ff.cnt));
        endproperty
        a_capture: assert property (p_capture) else $error("capture lost");

        property p_cmp_set;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && !s_ff.center_aligned_select && s_ff.ms[g] == 2'b01 && s_ff.el[g] == 2'b11
             && match[g]) ##1 I_CE |=> O_CH_PIN_OUT[g];
        endproperty
        a_cmp_set: assert property (p_cmp_set) else $error("compare set failed");

        property p_toggle_hold;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (!s_ff.center_aligned_select && s_ff.ms[g] == 2'b01 && s_ff.el[g] == 2'b01 && !match[g])
            |=> (s_ff.lvl[g] == $past(s_ff.lvl[g]));
        endproperty
        a_toggle_hold: assert property (p_toggle_hold) else $error("toggle early");

        property p_edge_aligned_pwm_start;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && !s_ff.center_aligned_select && s_ff.ms[g][1] && s_ff.el[g] == 2'b10 && tick
             && s_ff.cnt == 16'h0000 && !match[g]) ##1 I_CE |=> O_CH_PIN_OUT[g];
        endproperty
        a_edge_aligned_pwm_start: assert property (p_edge_aligned_pwm_start) else $error("pwm not set");

        property p_center_aligned_pwm_up;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && s_ff.center_aligned_select && s_ff.dir_up && s_ff.el[g] == 2'b10 && match[g])
            ##1 I_CE |=> !O_CH_PIN_OUT[g];
        endproperty
        a_center_aligned_pwm_up: assert property (p_center_aligned_pwm_up) else $error("center_aligned_pwm up not clear");

        property p_center_aligned_pwm_down;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && s_ff.center_aligned_select && !s_ff.dir_up && s_ff.el[g] == 2'b01 && match[g])
            ##1 I_CE |=> !O_CH_PIN_OUT[g];
        endproperty
        a_center_aligned_pwm_down: assert property (p_center_aligned_pwm_down) else $error("center_aligned_pwm down not clear");

        property p_edge_aligned_pwm_low;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && !s_ff.center_aligned_select && s_ff.ms[g][1] && s_ff.el[g] == 2'b01 && match[g])
            ##1 I_CE |=> O_CH_PIN_OUT[g];
        endproperty
        a_edge_aligned_pwm_low: assert property (p_edge_aligned_pwm_low) else $error("low-true pwm not set");

        property p_sw_timer;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && !s_ff.center_aligned_select && s_ff.ms[g] == 2'b01 && match[g]) |=> s_ff.flag[g];
        endproperty
        a_sw_timer: assert property (p_sw_timer) else $error("compare flag missing");

        // no capture may touch the value while center mode runs
        property p_center_aligned_pwm_hold;
            @(posedge I_REF_CLK) disable iff (I_RST)
            (I_CE && s_ff.center_aligned_select && !s_ff.wr_pend) |=> $stable(s_ff.val[g]);
        endproperty
        a_center_aligned_pwm_hold: assert property (p_center_aligned_pwm_hold) else $error("center value moved");
    end
endmodule

// file: verilog/timer_params.svh
// register map, field positions and channel count of the timer channel block
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH
`define TMR_NCH        4
`define TMR_CTRL_ADDR  8'h00
`define TMR_CNT_ADDR   8'h04
`define TMR_MOD_ADDR   8'h08
`define TMR_CHC_BASE   8'h20
`define TMR_CHV_BASE   8'h24
`define TMR_CH_STRIDE  8'h08
`define TMR_OVF_BIT    7
`define TMR_CENTER_ALIGNED_SELECT_BIT  5
`define TMR_CKS_LSB    3
`define TMR_PS_LSB     0
`define TMR_CHF_BIT    7
`define TMR_MS_LSB     4
`define TMR_EL_LSB     2
`endif

// file: verilog/timer_pkg.sv
// types of the timer channel block
`include "timer_params.svh"
package timer_pkg;
    typedef enum logic [1:0] {
        CKS_OFF,
        CKS_BUS,
        CKS_FIXED,
        CKS_EXT
    } clk_src_t;

    typedef struct packed {
        logic [31:0]                      hrdata;
        logic                             hreadyout;
        logic                             wr_pend;
        logic [7:0]                       wr_addr;
        logic                             ovf;
        logic                             center_aligned_select;
        clk_src_t                         cks;
        logic [2:0]                       ps;
        logic [15:0]                      cnt;
        logic [15:0]                      modv;
        logic                             dir_up;
        logic [6:0]                       presc;
        logic [1:0]                       fix_sync;
        logic                             fix_prev;
        logic [1:0]                       ext_sync;
        logic                             ext_prev;
        logic [`TMR_NCH-1:0][1:0]         ms;
        logic [`TMR_NCH-1:0][1:0]         el;
        logic [`TMR_NCH-1:0][15:0]        val;
        logic [`TMR_NCH-1:0]              flag;
        logic [`TMR_NCH-1:0]              cap_s1;
        logic [`TMR_NCH-1:0]              cap_s2;
        logic [`TMR_NCH-1:0]              cap_prev;
        logic [`TMR_NCH-1:0]              lvl;
        logic [`TMR_NCH-1:0]              pin_out;
        logic [`TMR_NCH-1:0]              pin_oe;
        logic [`TMR_NCH-1:0]              owned;
    } tmr_state_t;
endpackage

// file: dv/pin_partner.sv
// model of the far-side pins: edge sources and count clocks
`include "timer_params.svh"
`timescale 1ns/100ps
module pin_partner (
    input  wire logic                clk,
    input  wire logic [`TMR_NCH-1:0] pin_out,
    input  wire logic [`TMR_NCH-1:0] pin_oe,
    output logic                     ext_clk,
    output logic                     fixed_clk,
    output logic [`TMR_NCH-1:0]      pin_in
);
    logic [`TMR_NCH-1:0] drv;
    initial begin
        ext_clk = 1'b0;
        fixed_clk = 1'b0;
        drv = '0;
    end
    // wire level: a pin the timer drives reads back its own drive
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & drv);
    // ext clock is its own pin, never a channel pin
    // count clock at one eighth of bus rate, still between bursts
    task automatic pulses(input logic use_ext, input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            if (use_ext) ext_clk <= 1'b1; else fixed_clk <= 1'b1;
            repeat (4) @(posedge clk);
            if (use_ext) ext_clk <= 1'b0; else fixed_clk <= 1'b0;
        end
    endtask
    // new level held long enough for the synchroniser
    task automatic set_pin(input int ch, input logic v);
        @(posedge clk);
        drv[ch] <= v;
        repeat (8) @(posedge clk);
    endtask
endmodule

// file: dv/tb_top.sv
// self-checking testbench of the timer channel block
`timescale 1ns/100ps
`include "timer_params.svh"
module tb_top;
    import timer_pkg::*;
    logic clk, rst, ce, hsel, hwrite, rd_dp, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [3:0]  pin_out, pin_oe, owned, pin_in;
    logic        ext_clk, fixed_clk;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int fail_count, compares, cycles, seed, cv, e;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1; hsel = 1'b0; hwrite = 1'b0; rd_dp = 1'b0;
        ce = 1'b1;
        haddr = '0; hwdata = '0; htrans = 2'b00;
        fail_count = 0; compares = 0; cycles = 0; seed = 86;
    end
    timer_channel_pin_control u_timer_channel_pin_control (
        .I_REF_CLK(clk), .I_RST(rst), .I_CE(ce), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'b010), .I_HWDATA(hwdata),
        .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
        .I_FIXED_CLK(fixed_clk), .I_EXT_CLK(ext_clk), .I_CH_PIN_IN(pin_in),
        .O_CH_PIN_OUT(pin_out), .O_CH_PIN_OE(pin_oe), .O_CH_OWNED(owned));
    pin_partner u_pin_partner (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .ext_clk(ext_clk), .fixed_clk(fixed_clk), .pin_in(pin_in));
    task automatic cmp(input logic [31:0] got, input logic [31:0] want);
        compares++;
        if (got !== want) begin
            fail_count++;
            $display("BAD t=%0t value %h expected %h", $time, got, want);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d of %0d compares", fail_count, compares);
        if (fail_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one word transfer; a read notes its expectation for the monitor
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] m);
        hsel <= 1'b1; haddr <= {24'h0, a}; hwrite <= wr; htrans <= 2'b10;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= wr ? d : 32'h0;
        if (!wr) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
            rd_dp <= 1'b1;
        end
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd_dp <= 1'b0;
    endtask
    always @(posedge clk) begin
        if (rd_dp === 1'b1 && exp_q.size() > 0) begin
            cmp(hrdata & msk_q[0], exp_q[0] & msk_q[0]);
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    // high cycles of one pin over a whole number of periods
    task automatic hi_cnt(input int ch, input int n, input int want);
        int c;
        c = 0;
        repeat (20) @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            #1 if (pin_out[ch] === 1'b1) c++;
        end
        cmp(c, want);
    endtask
    function automatic logic [31:0] ctl(input logic cp, input logic [1:0] ck);
        return {26'h0, cp, ck, 3'b000};
    endfunction
    function automatic logic [31:0] chc(input logic [1:0] ms, input logic [1:0] el);
        return {26'h0, ms, el, 2'b00};
    endfunction
    function automatic logic [7:0] cha(input int n, input logic val);
        return `TMR_CHC_BASE + 8'(n) * `TMR_CH_STRIDE + (val ? 8'h04 : 8'h00);
    endfunction
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 cmp({pin_oe, owned}, 8'h00);
        bus(0, `TMR_CTRL_ADDR, 32'h0, 32'hffffffff);
        bus(0, cha(0, 0), 32'h0, 32'hffffffff);
        bus(0, 8'h1c, 32'h0, 32'hffffffff);
        // edge pwm, random duty, both polarities
        cv = 1 + ($unsigned($random(seed)) % 7);
        bus(1, `TMR_MOD_ADDR, 32'h8, 0);
        bus(1, cha(0, 1), cv, 0);
        bus(1, cha(1, 1), cv, 0);
        bus(1, cha(0, 0), chc(2'b10, 2'b10), 0);
        bus(1, cha(1, 0), chc(2'b10, 2'b01), 0);
        bus(1, `TMR_CTRL_ADDR, ctl(0, CKS_BUS), 0);
        hi_cnt(0, 90, 10 * cv);
        hi_cnt(1, 90, 10 * (9 - cv));
        // compare: set, clear, toggle every period
        bus(1, cha(2, 1), 32'h3, 0);
        bus(1, cha(2, 0), chc(2'b01, 2'b11), 0);
        hi_cnt(2, 18, 18);
        bus(1, cha(2, 0), chc(2'b01, 2'b10), 0);
        hi_cnt(2, 18, 0);
        bus(1, cha(2, 0), chc(2'b01, 2'b01), 0);
        hi_cnt(2, 90, 45);
        #1 cmp(pin_oe[2:0], 3'b111);
        bus(0, cha(2, 0), 32'h80, 32'h80);
        // capture edge selects: a rising edge flags under rising and either, not under falling
        for (e = 1; e < 4; e++) begin
            u_pin_partner.set_pin(3, 1'b0);
            bus(1, cha(3, 0), 32'h80 | chc(2'b00, e[1:0]), 0);
            u_pin_partner.set_pin(3, 1'b1);
            bus(0, cha(3, 0), (e == 2) ? 32'h04 << 1 : 32'h80, 32'h80);
        end
        #1 cmp({owned[3], pin_oe[3]}, 2'b10);
        // center-aligned pwm on every channel
        bus(1, cha(0, 1), 32'h5, 0);
        bus(1, cha(1, 1), 32'h5, 0);
        bus(1, `TMR_CTRL_ADDR, ctl(1, CKS_BUS), 0);
        hi_cnt(0, 160, 100);
        hi_cnt(1, 160, 60);
        #1 cmp(pin_oe[3], 1'b1);
        // any counter write restarts it, whatever the data
        bus(1, `TMR_CNT_ADDR, $random(seed), 0);
        bus(0, `TMR_CNT_ADDR, 32'h0, 32'hffff);
        // external count clock drives a pinless software timer; frozen edges are lost
        bus(1, `TMR_CTRL_ADDR, ctl(0, CKS_EXT), 0);
        bus(1, `TMR_CNT_ADDR, 32'h0, 0);
        bus(1, cha(2, 0), 32'h80 | chc(2'b01, 2'b00), 0);
        u_pin_partner.pulses(1'b1, 5);
        ce <= 1'b0;
        u_pin_partner.pulses(1'b1, 2);
        ce <= 1'b1;
        bus(0, `TMR_CNT_ADDR, 32'h5, 32'hffff);
        bus(0, cha(2, 0), 32'h80, 32'h80);
        #1 cmp({owned[2], pin_oe[2]}, 2'b00);
        // fixed clock as count source
        bus(1, `TMR_CTRL_ADDR, ctl(0, CKS_FIXED), 0);
        bus(1, `TMR_CNT_ADDR, 32'h0, 0);
        u_pin_partner.pulses(1'b0, 3);
        bus(0, `TMR_CNT_ADDR, 32'h3, 32'hffff);
        // clock off releases every pin; a second reset clears the channels
        bus(1, `TMR_CTRL_ADDR, ctl(0, CKS_OFF), 0);
        repeat (2) @(posedge clk);
        #1 cmp({owned, pin_oe}, 8'h00);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1 cmp({hresp, hready}, 2'b01);
        bus(0, cha(3, 0), 32'h0, 32'hffffffff);
        wrap_up();
    end
endmodule
